// ---- design/fsra_ctrl.sv ----
// Suspend/resume sequencer with acceleration mode for one flash die.
// Assumes host write/read cycles arrive as one-cycle strobes on mclk_i;
// the array itself is outside, reached by a status/data mux here.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "fsra_cfg.svh"

module fsra_ctrl
    import fsra_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire fsra_wr_s wr_bus_i,
    input wire logic [`FSRA_AW-1:0] rd_addr_i,
    input wire logic [15:0] array_data_i,
    input wire logic accel_voltage_input_i,
    input wire logic accel_low_i,
    input wire logic prog_done_i,
    input wire logic erase_done_i,
    input wire logic buf_abort_i,
    output fsra_rd_s rd_o,
    output logic prog_start_o,
    output logic prog_halt_o,
    output logic erase_halt_o,
    output logic bypass_o,
    output logic autosel_o,
    output logic lock_all_o
);
    fsra_state_e state_r, state_nxt;
    logic [`FSRA_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [1:0] bank_r, bank_nxt;
    logic [2:0] seq_r, seq_nxt;
    logic bypass_r, bypass_nxt;
    logic autosel_r, autosel_nxt;
    logic prog_in_es_r, prog_in_es_nxt;
    logic abort_r, abort_nxt;
    logic tog1_r, tog2_r;
    // Remembers a 90 write so that a following 00 ends bypass
    logic byp_rst1_r;
    logic [1:0] pins;
    logic acc_hv, acc_lo;
    logic sel_hit;

    // Pin levels reach the logic only through both synchroniser stages
    fsra_sync #(.W(2)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i({accel_voltage_input_i, accel_low_i}),
        .q_o(pins)
    );
    assign acc_hv = pins[1];
    assign acc_lo = pins[0];

    function automatic logic [1:0] bank_of(input logic [`FSRA_AW-1:0] a);
        bank_of = a[`FSRA_BANK_MSB:`FSRA_BANK_LSB];
    endfunction : bank_of

    function automatic logic [3:0] sect_of(input logic [`FSRA_AW-1:0] a);
        sect_of = a[`FSRA_SECT_MSB:`FSRA_SECT_LSB];
    endfunction : sect_of

    wire [15:0] wd = wr_bus_i.data;
    wire [`FSRA_AW-1:0] wa = wr_bus_i.addr;
    wire is_susp = wr_i && wd == `FSRA_CMD_SUSPEND;
    wire is_res = wr_i && wd == `FSRA_CMD_RESUME;
    wire bank_hit = bank_of(wa) == bank_r;
    wire in_es = state_r == ST_ES_READ || state_r == ST_ES_PROG;
    wire unlocked = seq_r == 3'd2;
    wire seq_pos = seq_r == 3'd5;
    wire mem_set = (state_r == ST_SEA_WIN && wr_i
                    && wd == `FSRA_CMD_SECT_ERASE)
                   || (state_r == ST_IDLE && seq_pos && wr_i
                       && wd == `FSRA_CMD_SECT_ERASE);
    wire mem_clr = state_r == ST_IDLE && !seq_pos;

    // Selection is cleared while idle so each erase starts with no sectors
    fsra_sectmem u_mem (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .set_i(mem_set),
        .clr_all_i(mem_clr),
        .waddr_i(sect_of(wa)),
        .raddr_i(sect_of(rd_addr_i)),
        .rdata_o(sel_hit)
    );

    // Unlock/command sequence tracker shared by all modes
    always_comb begin
        seq_nxt = seq_r;
        if (wr_i) begin
            case (seq_r)
                3'd0: seq_nxt = wd == `FSRA_CMD_UNLOCK1 ? 3'd1 : 3'd0;
                3'd1: seq_nxt = wd == `FSRA_CMD_UNLOCK2 ? 3'd2 : 3'd0;
                3'd2: seq_nxt = wd == `FSRA_CMD_ERASE_SETUP ? 3'd3 : 3'd0;
                3'd3: seq_nxt = wd == `FSRA_CMD_UNLOCK1 ? 3'd4 : 3'd0;
                3'd4: seq_nxt = wd == `FSRA_CMD_UNLOCK2 ? 3'd5 : 3'd0;
                default: seq_nxt = 3'd0;
            endcase
        end
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        bank_nxt = bank_r;
        bypass_nxt = bypass_r;
        autosel_nxt = autosel_r;
        prog_in_es_nxt = prog_in_es_r;
        abort_nxt = abort_r;
        prog_start_o = 1'b0;
        if (acc_hv)
            bypass_nxt = 1'b1;
        // Abort recovery waits for unlock, unlock, F0 even in bypass
        if (abort_r && unlocked && wr_i && wd == `FSRA_CMD_RESET)
            abort_nxt = 1'b0;
        // A fresh abort in the cycle of the recovery write wins
        if (buf_abort_i && (bypass_r || acc_hv))
            abort_nxt = 1'b1;
        // Autoselect entry/exit while suspended
        if ((state_r == ST_ES_READ || state_r == ST_PS) && !autosel_r
            && unlocked && wr_i && wd == `FSRA_CMD_AUTOSEL)
            autosel_nxt = 1'b1;
        else if (autosel_r && wr_i && wd == `FSRA_CMD_RESET)
            autosel_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (bypass_r && !acc_hv && wr_i) begin
                    // Two-write exit: 90 to bank, then 00
                    if (wd == `FSRA_CMD_AUTOSEL)
                        abort_nxt = abort_r;
                end
                if (seq_pos && wr_i && wd == `FSRA_CMD_SECT_ERASE
                    && !acc_lo && !abort_r) begin
                    state_nxt = ST_SEA_WIN;
                    cnt_nxt = '0;
                    bank_nxt = bank_of(wa);
                end else if (seq_pos && wr_i && wd == `FSRA_CMD_CHIP_ERASE
                             && !acc_lo && !abort_r) begin
                    state_nxt = ST_CHIP_ERASE;
                    // Status reads of the addressed bank see the erase
                    bank_nxt = bank_of(wa);
                end else if (wr_i && wd == `FSRA_CMD_PROG_SETUP
                             && (unlocked || bypass_r) && !acc_lo
                             && !abort_r) begin
                    state_nxt = ST_PROG;
                    prog_start_o = 1'b1;
                end
            end
            ST_SEA_WIN: begin
                cnt_nxt = cnt_r + 1'b1;
                if (is_susp && bank_hit) begin
                    state_nxt = ST_ES_READ;
                end else if (wr_i && wd != `FSRA_CMD_SECT_ERASE
                             && !(seq_r != 3'd0 || wd == `FSRA_CMD_UNLOCK1)) begin
                    state_nxt = ST_IDLE;
                end else if (wr_i) begin
                    cnt_nxt = '0;
                end else if (cnt_r >= `FSRA_CNT_W'(`FSRA_SEA_CYC)) begin
                    state_nxt = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (erase_done_i)
                    state_nxt = ST_IDLE;
                else if (is_susp && bank_hit) begin
                    state_nxt = ST_ES_WAIT;
                    cnt_nxt = '0;
                end
            end
            ST_ES_WAIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r >= `FSRA_CNT_W'(`FSRA_ESL_CYC - 1))
                    state_nxt = ST_ES_READ;
            end
            ST_ES_READ: begin
                if (is_res && bank_hit && !autosel_r)
                    state_nxt = ST_ERASE;
                else if (wr_i && wd == `FSRA_CMD_PROG_SETUP
                         && (unlocked || bypass_r) && !autosel_r) begin
                    state_nxt = ST_ES_PROG;
                    prog_start_o = 1'b1;
                    prog_in_es_nxt = 1'b1;
                end
            end
            ST_ES_PROG, ST_PROG: begin
                if (prog_done_i) begin
                    state_nxt = prog_in_es_r ? ST_ES_READ : ST_IDLE;
                    prog_in_es_nxt = 1'b0;
                end else if (is_susp) begin
                    state_nxt = ST_PS_WAIT;
                    cnt_nxt = '0;
                end
            end
            ST_PS_WAIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r >= `FSRA_CNT_W'(`FSRA_PSL_CYC - 1))
                    state_nxt = ST_PS;
            end
            ST_PS: begin
                if (is_res && !autosel_r)
                    state_nxt = prog_in_es_r ? ST_ES_PROG : ST_PROG;
            end
            ST_CHIP_ERASE: begin
                // Suspend written here is dropped
                if (erase_done_i)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Explicit bypass exit once the high voltage is gone
        if (bypass_r && !acc_hv && byp_rst1_r && wr_i
            && wd == `FSRA_CMD_BYP_RST2)
            bypass_nxt = 1'b0;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i)
            byp_rst1_r <= 1'b0;
        else if (wr_i)
            byp_rst1_r <= bypass_r && wd == `FSRA_CMD_AUTOSEL;
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            bank_r <= '0;
            seq_r <= '0;
            bypass_r <= 1'b0;
            autosel_r <= 1'b0;
            prog_in_es_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bank_r <= bank_nxt;
            seq_r <= seq_nxt;
            bypass_r <= bypass_nxt;
            autosel_r <= autosel_nxt;
            prog_in_es_r <= prog_in_es_nxt;
            abort_r <= abort_nxt;
        end
    end

    // Read path: status or array, one cycle after rd_i
    wire busy = state_r == ST_ERASE || state_r == ST_PROG
                || state_r == ST_ES_PROG || state_r == ST_CHIP_ERASE
                || state_r == ST_SEA_WIN;
    wire susp_wait = state_r == ST_ES_WAIT || state_r == ST_PS_WAIT;
    logic rd_bank_hit, rd_q;
    logic [15:0] arr_q;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rd_bank_hit <= 1'b0;
            rd_q <= 1'b0;
            arr_q <= '0;
            tog1_r <= 1'b0;
            tog2_r <= 1'b0;
        end else begin
            rd_bank_hit <= bank_of(rd_addr_i) == bank_r;
            rd_q <= rd_i;
            arr_q <= array_data_i;
            if (rd_i && busy && bank_of(rd_addr_i) == bank_r)
                tog1_r <= ~tog1_r;
            if (rd_i && (in_es || state_r == ST_ERASE)
                && bank_of(rd_addr_i) == bank_r)
                tog2_r <= ~tog2_r;
        end
    end

    // Status word is formed from the state and toggle bits seen with the read data
    logic [15:0] stat_w;
    always_comb begin
        stat_w = '0;
        stat_w[`FSRA_POLL_BIT] = in_es || state_r == ST_PS;
        stat_w[`FSRA_TOG1_BIT] = tog1_r;
        stat_w[`FSRA_TOG2_BIT] = tog2_r;
        stat_w[`FSRA_SEA_BIT] = state_r != ST_SEA_WIN;
    end

    wire show_stat = rd_bank_hit && (busy || susp_wait
                     || (sel_hit && in_es && !autosel_r));
    assign rd_o.dout = show_stat ? stat_w : arr_q;
    // Invalid for reads of the bank_r bank while the suspend is settling, or in nested suspended sectors
    assign rd_o.dout_valid = rd_q && !(rd_bank_hit && susp_wait)
                             && !(state_r == ST_PS && prog_in_es_r
                                  && sel_hit && !autosel_r);
    assign rd_o.busy = busy || susp_wait;
    assign prog_halt_o = state_r == ST_PS;
    // Erase stays suspended underneath a nested program suspend
    assign erase_halt_o = in_es || (prog_in_es_r && (state_r == ST_PS
                          || state_r == ST_PS_WAIT));
    assign bypass_o = bypass_r;
    assign autosel_o = autosel_r;
    assign lock_all_o = acc_lo;
endmodule : fsra_ctrl

// ---- common/fsra_cfg.svh ----
// Constants for the suspend/resume and acceleration controller.
// Assumes inclusion by the package and the design files by bare name.
`ifndef FSRA_CFG_SVH
`define FSRA_CFG_SVH

`define FSRA_AW 8
`define FSRA_BANKS 4
`define FSRA_BANK_MSB 7
`define FSRA_BANK_LSB 6
`define FSRA_SECT_MSB 7
`define FSRA_SECT_LSB 4
`define FSRA_NSECT 16

`define FSRA_CMD_SUSPEND 16'h00b0
`define FSRA_CMD_RESUME 16'h0030
`define FSRA_CMD_UNLOCK1 16'h00aa
`define FSRA_CMD_UNLOCK2 16'h0055
`define FSRA_CMD_RESET 16'h00f0
`define FSRA_CMD_AUTOSEL 16'h0090
`define FSRA_CMD_BYP_RST2 16'h0000
`define FSRA_CMD_PROG_SETUP 16'h00a0
`define FSRA_CMD_ERASE_SETUP 16'h0080
`define FSRA_CMD_SECT_ERASE 16'h0030
`define FSRA_CMD_CHIP_ERASE 16'h0010

// Times in ns, clock period in ns
`define FSRA_CLK_NS 4
`define FSRA_ESL_NS 20000
`define FSRA_PSL_NS 20000
`define FSRA_SEA_NS 50000
`define FSRA_ESL_CYC (`FSRA_ESL_NS / `FSRA_CLK_NS)
`define FSRA_PSL_CYC (`FSRA_PSL_NS / `FSRA_CLK_NS)
`define FSRA_SEA_CYC ((`FSRA_SEA_NS + `FSRA_CLK_NS - 1) / `FSRA_CLK_NS)
`define FSRA_CNT_W 16

`define FSRA_POLL_BIT 7
`define FSRA_TOG1_BIT 6
`define FSRA_TOG2_BIT 2
`define FSRA_SEA_BIT 3

`endif

// ---- common/fsra_pkg.sv ----
// Types for the suspend/resume and acceleration controller.
// Assumes fsra_cfg.svh is on the include path.
package fsra_pkg;
`include "fsra_cfg.svh"

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SEA_WIN = 4'b0001,
        ST_ERASE = 4'b0010,
        ST_ES_WAIT = 4'b0011,
        ST_ES_READ = 4'b0100,
        ST_ES_PROG = 4'b0101,
        ST_PROG = 4'b0110,
        ST_PS_WAIT = 4'b0111,
        ST_PS = 4'b1000,
        ST_CHIP_ERASE = 4'b1001
    } fsra_state_e;

    typedef struct packed {
        logic [`FSRA_AW-1:0] addr;
        logic [15:0] data;
    } fsra_wr_s;

    typedef struct packed {
        logic busy;
        logic [15:0] dout;
        logic dout_valid;
    } fsra_rd_s;
endpackage : fsra_pkg

// ---- design/fsra_sync.sv ----
// Two flip-flop synchroniser for the acceleration pin levels.
// Assumes pin levels are asynchronous to mclk_i.
`timescale 1ns/1ps
module fsra_sync #(
    parameter int W = 2
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule : fsra_sync

// ---- design/fsra_sectmem.sv ----
// Per-sector erase selection memory with registered read data.
// Assumes one clock; write and clear-all are from the sequencer.
`timescale 1ns/1ps
`include "fsra_cfg.svh"
module fsra_sectmem
    import fsra_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic set_i,
    input wire logic clr_all_i,
    input wire logic [3:0] waddr_i,
    input wire logic [3:0] raddr_i,
    output logic rdata_o
);
    logic [`FSRA_NSECT-1:0] sel_r;
    logic rdata_r;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            sel_r <= '0;
            rdata_r <= 1'b0;
        end else begin
            if (clr_all_i)
                sel_r <= '0;
            else if (set_i)
                sel_r[waddr_i] <= 1'b1;
            rdata_r <= sel_r[raddr_i];
        end
    end
    assign rdata_o = rdata_r;
endmodule : fsra_sectmem

// ---- bench/fsra_ctrl_sva.sv ----
// Port checker for the suspend/resume controller.
// Assumes one clock domain, synchronous active-low reset, bound below.
`timescale 1ns/1ps
`include "fsra_cfg.svh"
module fsra_ctrl_chk
    import fsra_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire fsra_wr_s wr_bus_i,
    input wire logic [`FSRA_AW-1:0] rd_addr_i,
    input wire logic [15:0] array_data_i,
    input wire logic accel_voltage_input_i,
    input wire logic accel_low_i,
    input wire logic prog_done_i,
    input wire logic erase_done_i,
    input wire logic buf_abort_i,
    input wire fsra_rd_s rd_o,
    input wire logic prog_start_o,
    input wire logic prog_halt_o,
    input wire logic erase_halt_o,
    input wire logic bypass_o,
    input wire logic autosel_o,
    input wire logic lock_all_o
);
    logic [1:0] susp_bank_r;
    wire logic is_susp = wr_i && wr_bus_i.data == `FSRA_CMD_SUSPEND;
    wire logic is_res = wr_i && wr_bus_i.data == `FSRA_CMD_RESUME;
    wire logic own_bank = wr_bus_i.addr[7:6] == susp_bank_r;
    wire logic quiet = !rd_o.busy && !erase_halt_o && !prog_halt_o;

    // Bank of the last suspend outside erase suspend; resume must match
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            susp_bank_r <= 2'h0;
        end else if (is_susp && !erase_halt_o) begin
            susp_bank_r <= wr_bus_i.addr[7:6];
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_RD_ANSWER: assert property (
        rd_o.dout_valid |-> $past(rd_i))
        else $error("Read data without a read strobe");
    AST_HALT_CAUSE: assert property (
        $rose(erase_halt_o) && $past(wr_i)
        |-> $past(wr_bus_i.data) == `FSRA_CMD_SUSPEND)
        else $error("Erase halted by a write that was not suspend");
    AST_ERASE_RESUME: assert property (
        erase_halt_o && !rd_o.busy && !prog_halt_o && !autosel_o && is_res
        && own_bank
        |-> ##[1:2] !erase_halt_o)
        else $error("Erase resume to the suspended bank not taken");
    AST_PROG_RESUME: assert property (
        prog_halt_o && !autosel_o && is_res |-> ##[1:2] !prog_halt_o)
        else $error("Program resume not taken");
    AST_LOCK_FOLLOWS: assert property (
        $stable(accel_low_i) [*4] |-> lock_all_o == accel_low_i)
        else $error("Sector lock does not follow the low accel level");
    AST_ACCEL_BYPASS: assert property (
        accel_voltage_input_i [*4] |-> bypass_o)
        else $error("High accel level without unlock bypass");
    AST_ARRAY_READ: assert property (
        rd_i && quiet && !autosel_o
        |=> rd_o.dout_valid && rd_o.dout == $past(array_data_i))
        else $error("Idle read did not return array data");
    AST_PROG_BUSY: assert property (
        prog_start_o |=> rd_o.busy)
        else $error("Program started without busy");
endmodule : fsra_ctrl_chk

bind fsra_ctrl fsra_ctrl_chk u_chk (
    .mclk_i, .nrst_i, .wr_i, .rd_i, .wr_bus_i, .rd_addr_i, .array_data_i,
    .accel_voltage_input_i, .accel_low_i, .prog_done_i, .erase_done_i,
    .buf_abort_i, .rd_o, .prog_start_o, .prog_halt_o, .erase_halt_o,
    .bypass_o, .autosel_o, .lock_all_o
);

// ---- bench/fsra_host.sv ----
// Host model: flash write and read cycles, array data, accel pin levels.
// Assumes each task is called just after a rising edge of mclk_i.
`timescale 1ns/1ps
module fsra_host
    import fsra_pkg::*;
(
    input wire logic mclk_i,
    output logic wr_o,
    output logic rd_o,
    output fsra_wr_s bus_o,
    output logic [7:0] rd_addr_o,
    output logic [15:0] arr_o,
    output logic hv_o,
    output logic low_o
);
    int acc_uses = 0;

    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        bus_o = 24'h0;
        rd_addr_o = 8'h0;
        arr_o = 16'h0;
        hv_o = 1'b0;
        low_o = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_o <= 1'b1;
        bus_o <= {a, d};
        if (hv_o && d == 16'h00a0) begin
            acc_uses++;
        end
        @(posedge mclk_i);
        wr_o <= 1'b0;
        bus_o <= ~{a, d};
    endtask : wr

    task rd(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        rd_o <= 1'b1;
        rd_addr_o <= a;
        arr_o <= d;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        rd_addr_o <= ~a;
        arr_o <= ~d;
    endtask : rd

    // High level only while unlocked and with fewer than 10 A0 writes made at the high level, counted over all addresses
    task accel(input logic hv, input logic lo);
        @(posedge mclk_i);
        hv_o <= hv && !lo && acc_uses < 10;
        low_o <= lo && !hv;
    endtask : accel
endmodule : fsra_host

// ---- bench/fsra_ctrl_bench.sv ----
// Self-checking bench for the suspend/resume and acceleration controller.
// Assumes fsra_host as the host side; done pulses come from this bench.
`timescale 1ns/1ps
`include "fsra_cfg.svh"
module fsra_ctrl_bench
    import fsra_pkg::*;
;
    typedef struct packed {
        logic [15:0] m;
        logic [15:0] e;
    } fsra_note_s;

    logic mclk_i, nrst_i, wr_i, rd_i;
    logic prog_done_i, erase_done_i, buf_abort_i;
    logic accel_voltage_input_i, accel_low_i;
    logic prog_start_o, prog_halt_o, erase_halt_o;
    logic bypass_o, autosel_o, lock_all_o;
    logic [7:0] rd_addr_i;
    logic [15:0] array_data_i;
    fsra_wr_s wr_bus_i;
    fsra_rd_s rd_o;
    fsra_note_s notes[$];
    fsra_note_s nt;
    logic [31:0] seed = 32'ha549be34;
    int n_fail = 0;
    int samples_checked = 0;

    fsra_ctrl dut (.mclk_i, .nrst_i, .wr_i, .rd_i, .wr_bus_i, .rd_addr_i,
        .array_data_i, .accel_voltage_input_i, .accel_low_i, .prog_done_i,
        .erase_done_i, .buf_abort_i, .rd_o, .prog_start_o, .prog_halt_o,
        .erase_halt_o, .bypass_o, .autosel_o, .lock_all_o);
    fsra_host host (.mclk_i, .wr_o(wr_i), .rd_o(rd_i), .bus_o(wr_bus_i),
        .rd_addr_o(rd_addr_i), .arr_o(array_data_i),
        .hv_o(accel_voltage_input_i), .low_o(accel_low_i));

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    function logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd

    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task chk1(input string nm, input logic s, input logic e);
        chk(nm, {15'h0, s}, {15'h0, e});
    endtask : chk1

    task print_verdict();
        $display("compared %0d mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // A zero mask means no valid read data may come back
    task rdx(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e,
        input bit arr);
        logic [15:0] d;
        d = rnd();
        if (m != 16'h0) begin
            notes.push_back('{m, arr ? d & m : e});
        end
        host.rd(a, d);
    endtask : rdx

    task ul(input logic [7:0] a, input logic [15:0] d);
        host.wr(a, `FSRA_CMD_UNLOCK1);
        host.wr(a, `FSRA_CMD_UNLOCK2);
        host.wr(a, d);
    endtask : ul

    task st();
        repeat (2) @(negedge mclk_i);
    endtask : st

    task pls(input bit er);
        @(posedge mclk_i);
        erase_done_i <= er;
        prog_done_i <= !er;
        @(posedge mclk_i);
        erase_done_i <= 1'b0;
        prog_done_i <= 1'b0;
    endtask : pls

    task wt(input bit p, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(negedge mclk_i);
            if ((p ? prog_halt_o : erase_halt_o) === 1'b1) begin
                break;
            end
        end
        if (n == lim) begin
            chk1("halt_wait", 1'b0, 1'b1);
            print_verdict();
        end
    endtask : wt

    always @(posedge mclk_i) begin
        if (rd_o.dout_valid === 1'b1) begin
            if (notes.size() == 0) begin
                chk1("stray_read", 1'b1, 1'b0);
            end else begin
                nt = notes.pop_front();
                chk("read_data", rd_o.dout & nt.m, nt.e);
            end
        end
    end

    initial begin
        int n;
        logic [15:0] r;
        nrst_i = 1'b0;
        prog_done_i = 1'b0;
        erase_done_i = 1'b0;
        buf_abort_i = 1'b0;
        repeat (16) @(posedge mclk_i);
        nrst_i <= 1'b1;
        st();
        chk1("lock_reset", lock_all_o, 1'b0);
        rdx(8'h12, 16'hffff, 16'h0, 1'b1);
        // Sector erase, suspended inside the selection window
        ul(8'h50, `FSRA_CMD_ERASE_SETUP);
        ul(8'h50, `FSRA_CMD_SECT_ERASE);
        host.wr(8'h40, `FSRA_CMD_SUSPEND);
        st();
        chk1("win_suspend", erase_halt_o, 1'b1);
        rdx(8'h53, 16'h0080, 16'h0080, 1'b0);
        rdx(8'hc3, 16'hffff, 16'h0, 1'b1);
        ul(8'hc3, `FSRA_CMD_PROG_SETUP);
        // Program data keeps bit 8 set so it never reads as a command
        host.wr(8'hc3, rnd() | 16'h0100);
        st();
        chk1("es_prog_busy", rd_o.busy, 1'b1);
        pls(1'b0);
        st();
        chk1("es_prog_back", erase_halt_o, 1'b1);
        ul(8'h40, `FSRA_CMD_AUTOSEL);
        st();
        chk1("es_autosel", autosel_o, 1'b1);
        host.wr(8'h40, `FSRA_CMD_RESET);
        host.wr(8'h40, `FSRA_CMD_RESUME);
        st();
        chk1("resume", erase_halt_o, 1'b0);
        host.wr(8'h40, `FSRA_CMD_RESUME);
        st();
        chk1("resume_again", rd_o.busy, 1'b1);
        host.wr(8'h90, `FSRA_CMD_SUSPEND);
        rdx(8'h53, 16'h0080, 16'h0000, 1'b0);
        host.wr(8'h40, `FSRA_CMD_SUSPEND);
        rdx(8'h53, 16'h0, 16'h0, 1'b0);
        wt(1'b0, `FSRA_ESL_CYC + 10, n);
        chk1("esl", n <= `FSRA_ESL_CYC + 1, 1'b1);
        host.wr(8'h40, `FSRA_CMD_RESUME);
        pls(1'b1);
        // Chip erase refuses suspend; status stays readable
        ul(8'h00, `FSRA_CMD_ERASE_SETUP);
        ul(8'h00, `FSRA_CMD_CHIP_ERASE);
        host.wr(8'h00, `FSRA_CMD_SUSPEND);
        st();
        chk1("chip_suspend", erase_halt_o, 1'b0);
        rdx(8'h00, 16'h0080, 16'h0000, 1'b0);
        pls(1'b1);
        // Program suspend with random address, autoselect inside it
        ul(8'h81, `FSRA_CMD_PROG_SETUP);
        host.wr(8'h81, rnd() | 16'h0100);
        r = rnd();
        host.wr(r[7:0], `FSRA_CMD_SUSPEND);
        wt(1'b1, `FSRA_PSL_CYC + 10, n);
        chk1("psl", n <= `FSRA_PSL_CYC + 1, 1'b1);
        rdx(8'h20, 16'hffff, 16'h0, 1'b1);
        ul(8'h20, `FSRA_CMD_AUTOSEL);
        st();
        chk1("ps_autosel", autosel_o, 1'b1);
        host.wr(8'h20, `FSRA_CMD_RESET);
        st();
        chk1("ps_back", prog_halt_o, 1'b1);
        host.wr(r[15:8], `FSRA_CMD_RESUME);
        st();
        chk1("ps_resume", prog_halt_o, 1'b0);
        host.wr(r[7:0], `FSRA_CMD_RESUME);
        st();
        chk1("ps_resume_again", rd_o.busy, 1'b1);
        pls(1'b0);
        // Another command inside the selection window ends it
        ul(8'h50, `FSRA_CMD_ERASE_SETUP);
        ul(8'h50, `FSRA_CMD_SECT_ERASE);
        host.wr(8'h50, `FSRA_CMD_RESET);
        st();
        rdx(8'h50, 16'hffff, 16'h0, 1'b1);
        // Acceleration: bypass programming, then exit and lock
        host.accel(1'b1, 1'b0);
        st();
        st();
        chk1("accel_bypass", bypass_o, 1'b1);
        // Buffer abort under bypass: a lone F0 must not recover
        @(posedge mclk_i);
        buf_abort_i <= 1'b1;
        @(posedge mclk_i);
        buf_abort_i <= 1'b0;
        host.wr(8'h81, `FSRA_CMD_RESET);
        host.wr(8'h81, `FSRA_CMD_PROG_SETUP);
        st();
        chk1("abort_hold", rd_o.busy, 1'b0);
        ul(8'h81, `FSRA_CMD_RESET);
        host.wr(8'h81, `FSRA_CMD_PROG_SETUP);
        host.wr(8'h81, rnd() | 16'h0100);
        st();
        chk1("accel_prog", rd_o.busy, 1'b1);
        pls(1'b0);
        host.accel(1'b0, 1'b0);
        st();
        host.wr(8'h40, `FSRA_CMD_AUTOSEL);
        host.wr(8'h40, `FSRA_CMD_BYP_RST2);
        st();
        chk1("bypass_exit", bypass_o, 1'b0);
        host.accel(1'b0, 1'b1);
        st();
        st();
        chk1("lock_all", lock_all_o, 1'b1);
        chk("notes_left", 16'(notes.size()), 16'h0);
        print_verdict();
    end
endmodule : fsra_ctrl_bench
